// >>> rtl/foc_readback_params.svh
// Offsets, field positions, reset values and codes for the algorithm readback bank.
// Assumes a plain register port with byte-offset addresses, 12 bits wide.
// Summary of operation
// - Current-loop proportional gain readback, bits 31-22
// - Current-loop integral gain readback, bits 21-12
// - Speed-loop proportional gain readback, bits 31-22
// - Speed-loop integral gain readback, bits 21-12
// - Speed gains at F2h, zero reset, low bits zero
// - State word at 210h, zero reset, upper half zero
// - Phase currents at 43Eh, 440h, 442h
// - Speed estimate 752h, angle estimate 756h
// - Dq currents 4E4h/4E6h, dq voltages 4E8h/4EAh
// - Speed target 5CCh, dq current targets 5FCh/5FEh
// - Sixteen-bit state codes 0h through 18h
// - Current gains at F0h, zero reset
`ifndef FOC_READBACK_PARAMS_SVH
`define FOC_READBACK_PARAMS_SVH

`define ADDR_CURRENT_GAINS 12'h0F0
`define ADDR_SPEED_GAINS 12'h0F2
`define ADDR_STATE_CODE 12'h210
`define ADDR_TACH_SPEED 12'h216
`define ADDR_BUS_CURRENT 12'h410
`define ADDR_PHASE_A_I 12'h43E
`define ADDR_PHASE_B_I 12'h440
`define ADDR_PHASE_C_I 12'h442
`define ADDR_AMP_GAIN 12'h466
`define ADDR_VOLT_GAIN 12'h476
`define ADDR_SUPPLY_V 12'h478
`define ADDR_PHASE_A_V 12'h47E
`define ADDR_PHASE_B_V 12'h480
`define ADDR_PHASE_C_V 12'h482
`define ADDR_ANGLE_SIN 12'h4BA
`define ADDR_ANGLE_COS 12'h4BC
`define ADDR_ALPHA_I 12'h4D4
`define ADDR_BETA_I 12'h4D6
`define ADDR_ALPHA_V 12'h4D8
`define ADDR_BETA_V 12'h4DA
`define ADDR_D_I 12'h4E4
`define ADDR_Q_I 12'h4E6
`define ADDR_D_V 12'h4E8
`define ADDR_Q_V 12'h4EA
`define ADDR_ALIGN_I 12'h524
`define ADDR_OL_SPEED 12'h53A
`define ADDR_OL_I 12'h548
`define ADDR_CL_SPEED 12'h5CC
`define ADDR_CL_D_I 12'h5FC
`define ADDR_CL_Q_I 12'h5FE
`define ADDR_SPIN_DETECT_PHASE 12'h67A
`define ADDR_SPIN_DETECT_RESULT 12'h684
`define ADDR_POS_DETECT_PHASE 12'h6B8
`define ADDR_POS_DETECT_ANGLE 12'h6FC
`define ADDR_BEMF_D 12'h742
`define ADDR_BEMF_Q 12'h744
`define ADDR_ROTOR_SPEED 12'h752
`define ADDR_ROTOR_ANGLE 12'h756

`define GAIN_KP_MSB 31
`define GAIN_KP_LSB 22
`define GAIN_KI_MSB 21
`define GAIN_KI_LSB 12
`define STATE_MSB 15
`define RESET_WORD 32'h0000_0000
`define STATE_LAST_CODE 16'h0018

`endif

// >>> rtl/foc_readback_pkg.sv
// Types shared by the algorithm readback bank.
// Assumes the params header is compiled alongside.
package foc_readback_pkg;

	// Number of 32-bit variable slots
	localparam int NUM_VARS = 36;

	// Algorithm state codes
	typedef enum logic [15:0] {
		ST_IDLE = 16'h0000,
		ST_SPEED_DETECT = 16'h0001,
		ST_TRISTATE = 16'h0002,
		ST_BRAKE_START = 16'h0003,
		ST_POSITION_DETECT = 16'h0004,
		ST_SLOW_FIRST = 16'h0005,
		ST_ALIGN = 16'h0006,
		ST_OPEN_LOOP = 16'h0007,
		ST_CLOSED_UNALIGNED = 16'h0008,
		ST_CLOSED_ALIGNED = 16'h0009,
		ST_ACTIVE_BRAKE = 16'h000A,
		ST_SOFT_STOP = 16'h000B,
		ST_RECIRC_STOP = 16'h000C,
		ST_BRAKE_STOP = 16'h000D,
		ST_FAULT = 16'h000E,
		ST_MEAS_STOP_CHECK = 16'h000F,
		ST_MEAS_STOP_WAIT = 16'h0010,
		ST_MEAS_BRAKE = 16'h0011,
		ST_MEAS_INIT = 16'h0012,
		ST_MEAS_RL = 16'h0013,
		ST_MEAS_KE = 16'h0014,
		ST_MEAS_STALL = 16'h0015,
		ST_MEAS_TORQUE = 16'h0016,
		ST_MEAS_DONE = 16'h0017,
		ST_MEAS_FAULT = 16'h0018
	} algo_state_t;

	// One loop's gains as used
	typedef struct packed {
		logic [9:0] kp;
		logic [9:0] ki;
	} loop_gains_t;

	// Register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// >>> rtl/foc_algorithm_readback_regs.sv
// Read-only readback bank for the field-oriented control algorithm.
// Assumes the algorithm core supplies gains, state and variables on one clock,
// with a one-cycle update strobe marking a consistent set of values.
`timescale 1ns/1ps
`include "foc_readback_params.svh"

module foc_algorithm_readback_regs
	import foc_readback_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire reg_req_t i_req,
	output logic [31:0] o_rdata,
	input wire loop_gains_t i_current_gains,
	input wire loop_gains_t i_speed_gains,
	input wire logic [15:0] i_state_code,
	input wire logic [NUM_VARS*32-1:0] i_vars,
	input wire logic i_update
);

	// Offsets of the variable slots, from the last slot down to slot 0
	localparam logic [NUM_VARS*12-1:0] VAR_ADDRS = {
		`ADDR_ROTOR_ANGLE, `ADDR_ROTOR_SPEED, `ADDR_BEMF_Q, `ADDR_BEMF_D,
		`ADDR_POS_DETECT_ANGLE, `ADDR_POS_DETECT_PHASE,
		`ADDR_SPIN_DETECT_RESULT, `ADDR_SPIN_DETECT_PHASE,
		`ADDR_CL_Q_I, `ADDR_CL_D_I, `ADDR_CL_SPEED, `ADDR_OL_I,
		`ADDR_OL_SPEED, `ADDR_ALIGN_I, `ADDR_Q_V, `ADDR_D_V,
		`ADDR_Q_I, `ADDR_D_I, `ADDR_BETA_V, `ADDR_ALPHA_V,
		`ADDR_BETA_I, `ADDR_ALPHA_I, `ADDR_ANGLE_COS, `ADDR_ANGLE_SIN,
		`ADDR_PHASE_C_V, `ADDR_PHASE_B_V, `ADDR_PHASE_A_V, `ADDR_SUPPLY_V,
		`ADDR_VOLT_GAIN, `ADDR_AMP_GAIN, `ADDR_PHASE_C_I, `ADDR_PHASE_B_I,
		`ADDR_PHASE_A_I, `ADDR_BUS_CURRENT, `ADDR_TACH_SPEED, `ADDR_STATE_CODE
	};

	// Snapshots taken together on each update strobe; rdata_r holds the registered read word
	loop_gains_t cur_gains_r;
	loop_gains_t spd_gains_r;
	logic [31:0] var_r [NUM_VARS];
	logic [31:0] rdata_r;

	// Per-slot address hits, gathered into one read word
	logic [NUM_VARS-1:0] var_hit;
	logic [31:0] var_word [NUM_VARS+1];

	// Out-of-range codes read as fault, so software never sees an undefined state
	wire logic [15:0] state_clean = (i_state_code > `STATE_LAST_CODE) ?
		ST_FAULT : i_state_code;

	// Packs one loop's gains into a register word
	function automatic logic [31:0] gain_word(input loop_gains_t g);
		gain_word = `RESET_WORD;
		gain_word[`GAIN_KP_MSB:`GAIN_KP_LSB] = g.kp;
		gain_word[`GAIN_KI_MSB:`GAIN_KI_LSB] = g.ki;
	endfunction

	// Gain snapshot; all fields change in the same edge
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cur_gains_r <= '0;
			spd_gains_r <= '0;
		end else if (i_update) begin
			cur_gains_r <= i_current_gains;
			spd_gains_r <= i_speed_gains;
		end
	end

	// Variable snapshots, one register per slot
	assign var_word[0] = `RESET_WORD;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_VARS; gi++) begin : g_var
			// Whole word captured at once, never byte by byte
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					var_r[gi] <= `RESET_WORD;
				end else if (i_update) begin
					if (gi == 0) begin
						var_r[gi] <= {16'h0000, state_clean};
					end else begin
						var_r[gi] <= i_vars[gi*32 +: 32];
					end
				end
			end
			assign var_hit[gi] = (i_req.addr == VAR_ADDRS[gi*12 +: 12]);
			assign var_word[gi+1] = var_word[gi] | (var_hit[gi] ? var_r[gi] : `RESET_WORD);
		end
	endgenerate

	// Read decode; writes are never decoded, so they change nothing
	wire logic hit_cur = (i_req.addr == `ADDR_CURRENT_GAINS);
	wire logic hit_spd = (i_req.addr == `ADDR_SPEED_GAINS);
	wire logic [31:0] rd_mux = hit_cur ? gain_word(cur_gains_r) :
		hit_spd ? gain_word(spd_gains_r) : var_word[NUM_VARS];

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_r <= `RESET_WORD;
		end else begin
			rdata_r <= i_req.rd ? rd_mux : `RESET_WORD;
		end
	end

	assign o_rdata = rdata_r;

endmodule // foc_algorithm_readback_regs

// >>> testbench/foc_readback_asserts.sv
// Checker on the readback bank ports, bound in at the foot.
// Assumes one clock and the async active-high reset.
`timescale 1ns/1ps
module foc_readback_asserts
	import foc_readback_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire reg_req_t i_req,
	input wire logic [31:0] o_rdata,
	input wire loop_gains_t i_current_gains,
	input wire loop_gains_t i_speed_gains,
	input wire logic [15:0] i_state_code,
	input wire logic [NUM_VARS*32-1:0] i_vars,
	input wire logic i_update
);
	// Shadow of the last captured set
	loop_gains_t cg_r, sg_r;
	logic [15:0] st_r;
	logic [NUM_VARS*32-1:0] v_r;
	// Read offset, or an unmapped one when idle
	wire [11:0] ra = i_req.rd ? i_req.addr : 12'h001;
	// Capture on the strobe only, so a read never sees half an update
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) {cg_r, sg_r, st_r, v_r} <= '0;
		else if (i_update) begin
			{cg_r, sg_r, v_r} <= {i_current_gains, i_speed_gains, i_vars};
			st_r <= i_state_code > 16'h0018 ? 16'h000E : i_state_code;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	property p_cg; ra == 12'h0F0 |=> o_rdata == {$past(cg_r), 12'h000}; endproperty
	a_cg: assert property (p_cg) else $error("current gains wrong");
	property p_sg; ra == 12'h0F2 |=> o_rdata == {$past(sg_r), 12'h000}; endproperty
	a_sg: assert property (p_sg) else $error("speed gains wrong");
	property p_st; ra == 12'h210 |=> o_rdata == {16'h0000, $past(st_r)}; endproperty
	a_st: assert property (p_st) else $error("state word wrong");
	property p_rg; ra == 12'h210 |=> o_rdata[15:0] <= 16'h0018; endproperty
	a_rg: assert property (p_rg) else $error("state code out of range");
	property p_quiet; !i_req.rd |=> o_rdata == '0; endproperty
	a_quiet: assert property (p_quiet) else $error("data without read");
	property p_ph; ra == 12'h43E |=> o_rdata == $past(v_r[96+:32]); endproperty
	a_ph: assert property (p_ph) else $error("phase current wrong");
	property p_sp; ra == 12'h752 |=> o_rdata == $past(v_r[1088+:32]); endproperty
	a_sp: assert property (p_sp) else $error("speed estimate wrong");
	property p_qvolt; ra == 12'h4EA |=> o_rdata == $past(v_r[672+:32]); endproperty
	a_qvolt: assert property (p_qvolt) else $error("q voltage wrong");
	property p_rf; ra == 12'h5FE |=> o_rdata == $past(v_r[864+:32]); endproperty
	a_rf: assert property (p_rf) else $error("q current target wrong");
	c_ur: cover property (i_update && i_req.rd);
	c_st: cover property (ra == 12'h210);
	c_wr: cover property (i_req.wr);
endmodule // foc_readback_asserts

bind foc_algorithm_readback_regs foc_readback_asserts u_chk (.i_core_clk, .i_rst, .i_req,
	.o_rdata, .i_current_gains, .i_speed_gains, .i_state_code, .i_vars, .i_update);

// >>> testbench/foc_algorithm_readback_regs_tb.sv
// Bench: reads queue expectations, a watcher checks results off the queue.
// Assumes the checker binds itself to the bank.
`timescale 1ns/1ps
module foc_algorithm_readback_regs_tb
	import foc_readback_pkg::*;
;
	logic i_core_clk, i_rst, i_update, seen;
	reg_req_t rq;
	logic [31:0] o_rdata, sd, q[$];
	loop_gains_t cg, sg, ecg, esg;
	logic [15:0] st, est;
	logic [NUM_VARS*32-1:0] vi, ev;
	int bad_count, num_checks;
	// Offsets read in turn; slot zero means gains, state or unmapped
	logic [11:0] ta[16] = '{12'h0F0, 12'h0F2, 12'h210, 12'h212, 12'h43E, 12'h440, 12'h442,
		12'h4E4, 12'h4E6, 12'h4E8, 12'h4EA, 12'h5CC, 12'h5FC, 12'h5FE, 12'h752, 12'h756};
	int sl[16] = '{0, 0, 0, 0, 3, 4, 5, 18, 19, 20, 21, 25, 26, 27, 34, 35};
	foc_algorithm_readback_regs dut (.i_core_clk, .i_rst, .i_req(rq), .o_rdata,
		.i_current_gains(cg), .i_speed_gains(sg), .i_state_code(st), .i_vars(vi), .i_update);
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	// Captured-set model, a half cycle early so queued reads see it in time
	always @(negedge i_core_clk) begin
		if (i_rst) {ecg, esg, est, ev} <= '0;
		else if (i_update) {ecg, esg, est, ev} <= {cg, sg, st > 16'h0018 ? 16'h000E : st, vi};
	end
	// Watcher: data stand one cycle after each read
	always @(posedge i_core_clk) seen <= rq.rd;
	always @(negedge i_core_clk) if (seen) check(o_rdata, q.pop_front());
	function automatic logic [31:0] rn();
		sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
		return sd;
	endfunction
	function automatic logic [31:0] ex(logic [11:0] a);
		logic [31:0] r = '0;
		foreach (ta[k]) if (ta[k] == a && sl[k] > 0) r = ev[sl[k]*32+:32];
		if (a == 12'h0F0) r = {ecg, 12'h000};
		if (a == 12'h0F2) r = {esg, 12'h000};
		if (a == 12'h210) r = {16'h0000, est};
		return r;
	endfunction
	task check(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	task rd(logic [11:0] a);
		rq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		q.push_back(ex(a));
		@(posedge i_core_clk);
	endtask
	// Writes aim at defined registers only
	task wr(logic [11:0] a);
		rq <= '{a, rn(), 1'b1, 1'b0};
		@(posedge i_core_clk);
	endtask
	// New algorithm values; the strobe is optional
	task upd(logic [15:0] c, logic u);
		void'(rn());
		cg <= sd[31:12];
		sg <= sd[19:0];
		st <= c;
		i_update <= u;
		for (int k = 0; k < NUM_VARS; k++) vi[k*32+:32] <= rn();
	endtask
	task idle();
		rq <= '0;
		i_update <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task rall();
		foreach (ta[k]) rd(ta[k]);
		idle();
	endtask
	task give_verdict();
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		i_rst = 1'b1;
		i_update = 1'b0;
		seen = 1'b0;
		rq = '0;
		{cg, sg, st, vi} = '0;
		sd = 32'h492d;
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rall();
		$display("reset values done");
		upd(16'h0007, 1'b1);
		@(posedge i_core_clk);
		idle();
		rall();
		$display("readback done");
		wr(12'h0F0);
		wr(12'h43E);
		upd(16'h0009, 1'b0);
		rall();
		$display("writes and unstrobed inputs done");
		// Each read meets the next update, so it must return the older code
		for (int c = 0; c < 26; c++) begin
			upd(c[15:0], 1'b1);
			rd(12'h210);
		end
		idle();
		rall();
		$display("state codes done");
		i_rst <= 1'b1;
		@(posedge i_core_clk);
		i_rst <= 1'b0;
		rall();
		$display("second reset done");
		give_verdict();
	end
	// Watchdog, far beyond the 137 cycles needed
	initial begin
		repeat (3000) @(posedge i_core_clk);
		bad_count++;
		give_verdict();
	end
endmodule // foc_algorithm_readback_regs_tb
